// ### ocs_bus_regs.sv
// AHB-Lite slave holding the control and status registers
// assumes single word transfers; answers with zero wait states, always OKAY
`timescale 1ns/1ps
`include "ocs_cfg.svh"

module ocs_bus_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] status_word,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output ocs_pkg::ocs_cfg_type cfg
);

    logic wr_pend;
    logic [31:0] wr_addr;
    logic addr_take;
    ocs_pkg::ocs_cfg_type next_cfg;

    function automatic logic is_ctrl(input logic [31:0] a);
        is_ctrl = (a == `OCS_ADDR_CTRL);
    endfunction : is_ctrl

    function automatic logic [31:0] cfg_word(input ocs_pkg::ocs_cfg_type c);
        cfg_word = {25'h000_0000, c};
    endfunction : cfg_word

    // hsize is accepted as word; narrower sizes are treated as a full word
    assign addr_take = hsel && htrans[1] && hready;
    assign next_cfg = ocs_pkg::ocs_cfg_type'(hwdata[6:0]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h0000_0000;
        end else begin
            wr_pend <= addr_take && hwrite;
            wr_addr <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= '{1'b0, 1'b0, 1'b0, `OCS_RST_TB_SEL, `OCS_RST_MAIN_SEL};
        end else if (wr_pend && is_ctrl(wr_addr)) begin
            cfg <= next_cfg;
        end
    end

    // a read right behind a write to the same word sees the new value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            if (is_ctrl(haddr)) begin
                hrdata <= (wr_pend && is_ctrl(wr_addr)) ? cfg_word(next_cfg) : cfg_word(cfg);
            end else if (haddr == `OCS_ADDR_STATUS) begin
                hrdata <= status_word;
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule : ocs_bus_regs

// ### ocs_cfg.svh
// constants of the oscillator clock select and gating block
// assumes a single 10 MHz hclk domain and an AHB-Lite register port
//
// How it works
// [RL1] crystal selected: output pin carries the crystal amplifier's inverted input.
// [RL2] rc or internal selected: output pin carries the internal bus clock.
// [RL3] system integration enable turns the selected oscillator on or off.
// [RL4] main reference clock comes from the selected oscillator.
// [RL5] loop reference clock is a buffered copy of the main reference.
// [RL6] a separate timebase reference clock drives the timebase counter.
// [RL7] wait mode leaves both reference clocks running.
// [RL8] stop halts crystal or rc unless its keep-alive bit was set.
// [RL9] internal oscillator runs in stop unless stop-disable bit was set.
// [RL10] break state leaves the main reference clock running.
// [RL11] clock generator halves oscillator or divided loop clock for base clock.
// [RL12] system integration makes the bus clock at half the base clock.
// [RL13] main select code: 01 internal, 10 rc, 11 crystal, 00 unused.
// [RL14] timebase select code: 00 internal, 01 rc, 10 crystal, 11 unused.
// [RL15] rc or crystal reach the timebase only when also the main source.
// [RL16] rc and crystal oscillators never run together.
// [RL17] stop bits captured at stop entry; halted oscillators restart on exit.
`ifndef OCS_CFG_SVH
`define OCS_CFG_SVH

`define OCS_CLK_PERIOD_NS 100

`define OCS_ADDR_CTRL 32'h0000_0000
`define OCS_ADDR_STATUS 32'h0000_0004

`define OCS_MAIN_UNUSED 2'h0
`define OCS_MAIN_INTERNAL 2'h1
`define OCS_MAIN_RC 2'h2
`define OCS_MAIN_CRYSTAL 2'h3

`define OCS_TB_INTERNAL 2'h0
`define OCS_TB_RC 2'h1
`define OCS_TB_CRYSTAL 2'h2
`define OCS_TB_UNUSED 2'h3

`define OCS_CTRL_MAIN_LSB 0
`define OCS_CTRL_TB_LSB 2
`define OCS_CTRL_KEEP_XTAL_BIT 4
`define OCS_CTRL_KEEP_RC_BIT 5
`define OCS_CTRL_DIS_INT_BIT 6

`define OCS_RST_MAIN_SEL 2'h1
`define OCS_RST_TB_SEL 2'h0

`endif

// ### ocs_clock_ctrl.sv
// top of the oscillator clock select and gating block
// assumes oscillator outputs and pins are sampled levels synchronous to hclk;
// wait, break and stop levels come from system integration
`timescale 1ns/1ps
`include "ocs_cfg.svh"

module ocs_clock_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic osc_input_pin,
    input wire logic internal_osc_clock,
    input wire logic rc_osc_clock,
    input wire logic crystal_osc_clock,
    input wire logic bus_clock,
    input wire logic sysint_osc_enable,
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic break_state,
    output logic osc_output_pin,
    output logic main_ref_clock,
    output logic loop_ref_clock,
    output logic timebase_ref_clock,
    output logic internal_osc_en,
    output logic rc_osc_en,
    output logic crystal_osc_en
);

    ////////////////////////////////////////////////////////////////////////////
    ocs_pkg::ocs_cfg_type cfg;
    ocs_pkg::ocs_en_type osc_en;
    logic in_stop;
    logic [2:0] stop_bits;
    logic [31:0] status_word;
    logic next_main;
    logic next_tb;
    logic next_pin;
    logic [1:0] seen_mode;

    ocs_bus_regs u_regs (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .status_word(status_word),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .cfg(cfg)
    );

    ocs_src_ctrl u_src (
        .hclk(hclk),
        .hresetn(hresetn),
        .cfg(cfg),
        .sysint_osc_enable(sysint_osc_enable),
        .stop_mode(stop_mode),
        .osc_en(osc_en),
        .in_stop(in_stop),
        .stop_bits(stop_bits)
    );

    ////////////////////////////////////////////////////////////////////////////
    // wait and break are reported only; they never gate a clock
    assign status_word = {22'h00_0000, seen_mode, stop_bits, in_stop,
                          osc_en.crystal, osc_en.rc, osc_en.internal, main_ref_clock}; // RL7 RL10

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_mode <= 2'h0;
        end else begin
            seen_mode <= {break_state, wait_mode};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_main = 1'b0;
        if (cfg.main_sel == `OCS_MAIN_INTERNAL) begin
            next_main = internal_osc_clock && osc_en.internal; // RL4 RL13
        end else if (cfg.main_sel == `OCS_MAIN_RC) begin
            next_main = rc_osc_clock && osc_en.rc; // RL4 RL13
        end else if (cfg.main_sel == `OCS_MAIN_CRYSTAL) begin
            next_main = crystal_osc_clock && osc_en.crystal; // RL4 RL13
        end
    end

    // rc and crystal reach the timebase only while they are also main source
    always_comb begin
        next_tb = 1'b0;
        if (cfg.tb_sel == `OCS_TB_INTERNAL) begin
            next_tb = internal_osc_clock && osc_en.internal; // RL14
        end else if (cfg.tb_sel == `OCS_TB_RC && cfg.main_sel == `OCS_MAIN_RC) begin
            next_tb = rc_osc_clock && osc_en.rc; // RL14 RL15
        end else if (cfg.tb_sel == `OCS_TB_CRYSTAL && cfg.main_sel == `OCS_MAIN_CRYSTAL) begin
            next_tb = crystal_osc_clock && osc_en.crystal; // RL14 RL15
        end
    end

    always_comb begin
        if (cfg.main_sel == `OCS_MAIN_CRYSTAL) begin
            next_pin = osc_en.crystal && !osc_input_pin; // RL1
        end else begin
            next_pin = bus_clock; // RL2
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_ref_clock <= 1'b0;
            loop_ref_clock <= 1'b0;
        end else begin
            main_ref_clock <= next_main; // RL4 RL7 RL10
            loop_ref_clock <= next_main; // RL5
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timebase_ref_clock <= 1'b0;
        end else begin
            timebase_ref_clock <= next_tb; // RL6 RL7
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_output_pin <= 1'b0;
        end else begin
            osc_output_pin <= next_pin;
        end
    end

    // enables are a second copy so the pins come from flops of this module
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            internal_osc_en <= 1'b1;
            rc_osc_en <= 1'b0;
            crystal_osc_en <= 1'b0;
        end else begin
            internal_osc_en <= osc_en.internal; // RL3
            rc_osc_en <= osc_en.rc; // RL3 RL16
            crystal_osc_en <= osc_en.crystal; // RL3 RL16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    xtal_pin_drive_a: assert property ( // RL1
        cfg.main_sel == `OCS_MAIN_CRYSTAL && osc_en.crystal |=> osc_output_pin == !$past(osc_input_pin))
        else $error("output pin not the inverted crystal input");

    bus_pin_drive_a: assert property ( // RL2
        cfg.main_sel != `OCS_MAIN_CRYSTAL |=> osc_output_pin == $past(bus_clock))
        else $error("output pin not the bus clock");

    enable_follows_sysint_a: assert property ( // RL3
        !sysint_osc_enable ##1 !sysint_osc_enable |-> ##1 !rc_osc_en ##1 !rc_osc_en)
        else $error("rc oscillator enabled without system enable");

    main_ref_source_a: assert property ( // RL4
        cfg.main_sel == `OCS_MAIN_RC && osc_en.rc |=> main_ref_clock == $past(rc_osc_clock))
        else $error("main reference not taken from rc oscillator");

    loop_ref_copy_a: assert property ( // RL5
        loop_ref_clock == main_ref_clock)
        else $error("loop reference differs from main reference");

    tb_internal_path_a: assert property ( // RL6
        cfg.tb_sel == `OCS_TB_INTERNAL && osc_en.internal
        |=> timebase_ref_clock == $past(internal_osc_clock))
        else $error("timebase reference not the internal clock");

    wait_no_effect_a: assert property ( // RL7
        $rose(wait_mode) && !stop_mode && $stable(stop_mode) && $stable(cfg) && $stable(sysint_osc_enable)
        |=> osc_en == $past(osc_en))
        else $error("wait mode changed an oscillator enable");

    break_no_effect_a: assert property ( // RL10
        $rose(break_state) && !stop_mode && $stable(stop_mode) && $stable(cfg) && $stable(sysint_osc_enable)
        |=> osc_en == $past(osc_en))
        else $error("break changed an oscillator enable");

    stop_halts_xtal_a: assert property ( // RL8
        stop_mode && !in_stop && !cfg.stop_keep_crystal |=> !osc_en.crystal)
        else $error("crystal kept running in stop without keep-alive");

    stop_keeps_rc_a: assert property ( // RL8
        stop_mode && !in_stop && cfg.stop_keep_rc && cfg.main_sel == `OCS_MAIN_RC && sysint_osc_enable
        |=> osc_en.rc)
        else $error("rc halted in stop despite keep-alive");

    internal_in_stop_a: assert property ( // RL9
        stop_mode && in_stop && !stop_bits[2] && cfg.main_sel != `OCS_MAIN_INTERNAL |=> osc_en.internal)
        else $error("internal oscillator stopped without stop-disable");

    main_unused_code_a: assert property ( // RL13
        cfg.main_sel == `OCS_MAIN_UNUSED |=> !main_ref_clock && !osc_en.rc && !osc_en.crystal)
        else $error("unused main code produced a clock");

    tb_gated_source_a: assert property ( // RL15
        cfg.tb_sel == `OCS_TB_CRYSTAL && cfg.main_sel != `OCS_MAIN_CRYSTAL |=> !timebase_ref_clock)
        else $error("crystal reached timebase while not main source");

    tb_unused_code_a: assert property ( // RL14
        cfg.tb_sel == `OCS_TB_UNUSED |=> !timebase_ref_clock)
        else $error("unused timebase code produced a clock");

    never_both_a: assert property ( // RL16
        !(osc_en.rc && osc_en.crystal) && !(rc_osc_en && crystal_osc_en))
        else $error("rc and crystal enabled together");

    stop_capture_a: assert property ( // RL17
        stop_mode && !in_stop |=> stop_bits == $past({cfg.stop_disable_internal, cfg.stop_keep_rc,
                                                       cfg.stop_keep_crystal}))
        else $error("stop bits not captured at stop entry");

    restart_on_exit_a: assert property ( // RL17
        $fell(stop_mode) && sysint_osc_enable && cfg.main_sel == `OCS_MAIN_CRYSTAL && $stable(cfg)
        |=> osc_en.crystal ##1 crystal_osc_en)
        else $error("crystal did not restart after stop");

    xtal_stop_cycle_c: cover property (
        cfg.main_sel == `OCS_MAIN_CRYSTAL && osc_en.crystal ##1 stop_mode [*3] ##1 !stop_mode ##1 osc_en.crystal);

    keep_alive_stop_c: cover property (
        stop_mode && in_stop && osc_en.rc);

    internal_off_stop_c: cover property (
        stop_mode && in_stop && !osc_en.internal);

    tb_from_rc_c: cover property (
        cfg.tb_sel == `OCS_TB_RC && cfg.main_sel == `OCS_MAIN_RC && timebase_ref_clock);

endmodule : ocs_clock_ctrl

// ### ocs_pkg.sv
// types shared by the oscillator clock select block
// assumes the constants of ocs_cfg.svh
package ocs_pkg;

    typedef struct packed {
        logic stop_disable_internal;
        logic stop_keep_rc;
        logic stop_keep_crystal;
        logic [1:0] tb_sel;
        logic [1:0] main_sel;
    } ocs_cfg_type;

    typedef struct packed {
        logic crystal;
        logic rc;
        logic internal;
    } ocs_en_type;

    typedef enum logic {
        OCS_RUN,
        OCS_STOPPED
    } ocs_pwr_state_type;

endpackage : ocs_pkg

// ### ocs_src_ctrl.sv
// oscillator enables and stop-mode sequencing
// assumes stop_mode is a level from system integration, synchronous to hclk
`timescale 1ns/1ps
`include "ocs_cfg.svh"

module ocs_src_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input ocs_pkg::ocs_cfg_type cfg,
    input wire logic sysint_osc_enable,
    input wire logic stop_mode,
    output ocs_pkg::ocs_en_type osc_en,
    output logic in_stop,
    output logic [2:0] stop_bits
);

    ocs_pkg::ocs_pwr_state_type state;
    ocs_pkg::ocs_en_type next_en;
    logic [2:0] live_bits;
    logic [2:0] eff_bits;

    assign live_bits = {cfg.stop_disable_internal, cfg.stop_keep_rc, cfg.stop_keep_crystal};
    // in stop the captured copy rules; later writes wait for the next entry
    assign eff_bits = (state == ocs_pkg::OCS_STOPPED) ? stop_bits : live_bits; // RL17

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ocs_pkg::OCS_RUN;
            stop_bits <= 3'h0;
        end else begin
            case (state)
                ocs_pkg::OCS_RUN: begin
                    if (stop_mode) begin
                        state <= ocs_pkg::OCS_STOPPED;
                        stop_bits <= live_bits; // RL17
                    end
                end
                ocs_pkg::OCS_STOPPED: begin
                    if (!stop_mode) begin
                        state <= ocs_pkg::OCS_RUN;
                    end
                end
                default: begin
                    state <= ocs_pkg::OCS_RUN;
                end
            endcase
        end
    end

    always_comb begin
        // only the selected one of rc and crystal may run: they share the input pin
        next_en.crystal = sysint_osc_enable && (cfg.main_sel == `OCS_MAIN_CRYSTAL)
                          && (!stop_mode || eff_bits[0]); // RL3 RL8 RL16
        next_en.rc = sysint_osc_enable && (cfg.main_sel == `OCS_MAIN_RC)
                     && (!stop_mode || eff_bits[1]); // RL3 RL8 RL16
        // internal stays up for the timebase even when another source is main
        next_en.internal = (sysint_osc_enable || cfg.main_sel != `OCS_MAIN_INTERNAL)
                           && !(stop_mode && eff_bits[2]); // RL3 RL9
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_en <= 3'h1;
            in_stop <= 1'b0;
        end else begin
            osc_en <= next_en; // RL17
            in_stop <= stop_mode;
        end
    end

endmodule : ocs_src_ctrl

// ### ocs_sysint_model.sv
// far-side model: system integration and clock generator logic
// assumes the reference clock and all requests are levels in the hclk domain
`timescale 1ns/1ps

module ocs_sysint_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic main_ref_clock,
    input wire logic enable_req,
    input wire logic stop_req,
    input wire logic wait_req,
    input wire logic break_req,
    output logic sysint_osc_enable,
    output logic stop_mode,
    output logic wait_mode,
    output logic break_state,
    output logic bus_clock
);
    logic ref_q;
    logic base_clock_out;

    ////////////////////////////////////////////////////////////////
    // mode levels, one register stage like a real sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sysint_osc_enable <= 1'b0;
            stop_mode <= 1'b0;
            wait_mode <= 1'b0;
            break_state <= 1'b0;
        end else begin
            sysint_osc_enable <= enable_req;
            stop_mode <= stop_req;
            wait_mode <= wait_req;
            break_state <= break_req;
        end
    end

    ////////////////////////////////////////////////////////////////
    // loop path not modelled: base clock always from the oscillator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_q <= 1'b0;
            base_clock_out <= 1'b0;
            bus_clock <= 1'b0;
        end else begin
            ref_q <= main_ref_clock;
            if (main_ref_clock && !ref_q) begin
                base_clock_out <= !base_clock_out;
                if (!base_clock_out) begin
                    bus_clock <= !bus_clock;
                end
            end
        end
    end
endmodule : ocs_sysint_model

// ### tb_osc_clock_select_gating.sv
// self-checking bench of the oscillator clock select and gating block
// assumes the design files and ocs_sysint_model are compiled first
`timescale 1ns/1ps
`include "ocs_cfg.svh"

module tb_osc_clock_select_gating;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd, rv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic osc_input_pin, internal_osc_clock, rc_osc_clock, crystal_osc_clock, bus_clock;
    logic sysint_osc_enable, stop_mode, wait_mode, break_state;
    logic osc_output_pin, main_ref_clock, loop_ref_clock, timebase_ref_clock;
    logic internal_osc_en, rc_osc_en, crystal_osc_en;
    logic enable_req, stop_req, wait_req, break_req, rnd_on, chk_on;
    logic [6:0] cfg_m;
    logic [2:0] cap, q_en, e_en;
    logic [3:0] p_clk;
    logic p_bus, p_sys, p_stop, pp_stop, e_main;
    integer seed, err_total, num_checks, i;

    assign hready = hreadyout;

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    ocs_clock_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .osc_input_pin(osc_input_pin),
        .internal_osc_clock(internal_osc_clock), .rc_osc_clock(rc_osc_clock),
        .crystal_osc_clock(crystal_osc_clock), .bus_clock(bus_clock), .sysint_osc_enable(sysint_osc_enable),
        .stop_mode(stop_mode), .wait_mode(wait_mode), .break_state(break_state),
        .osc_output_pin(osc_output_pin), .main_ref_clock(main_ref_clock), .loop_ref_clock(loop_ref_clock),
        .timebase_ref_clock(timebase_ref_clock), .internal_osc_en(internal_osc_en),
        .rc_osc_en(rc_osc_en), .crystal_osc_en(crystal_osc_en));

    ocs_sysint_model far_side (.hclk(hclk), .hresetn(hresetn), .main_ref_clock(main_ref_clock),
        .enable_req(enable_req), .stop_req(stop_req), .wait_req(wait_req), .break_req(break_req),
        .sysint_osc_enable(sysint_osc_enable), .stop_mode(stop_mode), .wait_mode(wait_mode),
        .break_state(break_state), .bus_clock(bus_clock));

    ////////////////////////////////////////////////////////////////
    // expected enables {crystal, rc, internal}
    function automatic logic [2:0] exp_en(input logic [6:0] c, input logic s, input logic st,
        input logic [2:0] k);
        exp_en[2] = (c[1:0] == 2'h3) && s && !(st && !k[0]);
        exp_en[1] = (c[1:0] == 2'h2) && s && !(st && !k[1]);
        exp_en[0] = ((c[1:0] == 2'h1) ? s : 1'b1) && !(st && k[2]);
    endfunction : exp_en

    function automatic logic pick(input integer n, input logic [2:0] c, input logic [2:0] e);
        pick = (n >= 0 && n <= 2) ? (c[n] & e[n]) : 1'b0;
    endfunction : pick

    task automatic cmp_bit(input logic e, input logic a);
        num_checks++;
        if (a !== e) begin
            err_total++;
            $display("mismatch at %0t ns: expected %h actual %h", $time, e, a);
        end
    endtask : cmp_bit

    task automatic cmp_word(input logic [31:0] e, input logic [31:0] a);
        num_checks++;
        if (a !== e) begin
            err_total++;
            $display("mismatch at %0t ns: expected %h actual %h", $time, e, a);
        end
    endtask : cmp_word

    ////////////////////////////////////////////////////////////////
    // one single transfer, entered just after a rising edge
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        integer n;
        n = 0;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 100) begin
            @(posedge hclk);
            n++;
        end
        r = hrdata;
        cmp_bit(1'b0, hresp);
        if (n >= 50) err_total++;
    endtask : ahb

    task automatic cfg_wr(input logic [6:0] c);
        chk_on = 1'b0;
        rnd_on = 1'b0;
        ahb(1'b1, `OCS_ADDR_CTRL, {25'h0, c}, rd);
        cfg_m = c;
        ahb(1'b0, `OCS_ADDR_CTRL, 32'h0000_0000, rd);
        cmp_word({25'h0, c}, rd);
        repeat (3) @(posedge hclk);
    endtask : cfg_wr

    task automatic stat_chk;
        ahb(1'b0, `OCS_ADDR_STATUS, 32'h0000_0000, rd);
        cmp_word({22'h0, break_req, wait_req, cap, p_stop, e_en, 1'b0}, rd & 32'h0000_03fe);
    endtask : stat_chk

    // random traffic with the port checker on, then a status read once levels settle
    task automatic run(input integer n);
        rnd_on = 1'b1;
        chk_on = 1'b1;
        repeat (n) @(posedge hclk);
        chk_on = 1'b0;
        rnd_on = 1'b0;
        repeat (4) @(posedge hclk);
        stat_chk();
    endtask : run

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////
    always @(posedge hclk) begin
        rv = $random(seed);
        {osc_input_pin, crystal_osc_clock, rc_osc_clock, internal_osc_clock} <= rv[3:0];
        if (rnd_on) begin
            enable_req <= (rv[6:4] != 3'h0);
            wait_req <= rv[7];
            break_req <= rv[8];
            if (rv[12:9] == 4'h0) stop_req <= !stop_req;
        end
    end

    // outputs compared against inputs seen one negedge earlier; the enable outputs against inputs two negedges earlier
    always @(negedge hclk) begin
        if (p_stop && !pp_stop) cap = cfg_m[6:4];
        e_en = exp_en(cfg_m, p_sys, p_stop, cap);
        e_main = pick(int'(cfg_m[1:0]) - 1, p_clk[2:0], q_en);
        if (chk_on) begin
            cmp_bit(q_en[2], crystal_osc_en);
            cmp_bit(q_en[1], rc_osc_en);
            cmp_bit(q_en[0], internal_osc_en);
            cmp_bit(1'b0, rc_osc_en & crystal_osc_en);
            cmp_bit(e_main, main_ref_clock);
            cmp_bit(e_main, loop_ref_clock);
            cmp_bit(pick((cfg_m[3:2] == 2'h3) ? -1 : int'(cfg_m[3:2]), p_clk[2:0], q_en), timebase_ref_clock);
            cmp_bit((cfg_m[1:0] == 2'h3) ? (q_en[2] & ~p_clk[3]) : p_bus, osc_output_pin);
        end
        pp_stop = p_stop;
        p_stop = stop_mode;
        p_sys = sysint_osc_enable;
        p_bus = bus_clock;
        p_clk = {osc_input_pin, crystal_osc_clock, rc_osc_clock, internal_osc_clock};
        q_en = e_en;
    end

    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        results();
    end

    initial begin
        seed = 32'hbf12_ba70;
        err_total = 0;
        num_checks = 0;
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {osc_input_pin, internal_osc_clock, rc_osc_clock, crystal_osc_clock} = 4'h0;
        {stop_req, wait_req, break_req, rnd_on, chk_on} = 5'h00;
        enable_req = 1'b1;
        {cap, q_en, p_clk, p_bus, p_sys, p_stop, pp_stop} = '0;
        cfg_m = 7'h01;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, `OCS_ADDR_CTRL, 32'h0000_0000, rd);
        cmp_word(32'h0000_0001, rd);
        ahb(1'b1, 32'h0000_0010, 32'h0000_007e, rd);
        ahb(1'b0, 32'h0000_0010, 32'h0000_0000, rd);
        cmp_word(32'h0000_0000, rd);
        repeat (3) @(posedge hclk);
        e_en = exp_en(cfg_m, 1'b1, 1'b0, 3'h0);
        stat_chk();
        $display("test reset_values done, mismatches %0d", err_total);
        for (i = 0; i < 16; i++) begin
            cfg_wr({3'h0, i[3:0]});
            run(40);
        end
        $display("test source_select done, mismatches %0d", err_total);
        for (i = 0; i < 24; i++) begin
            rv = $random(seed);
            cfg_wr({i[2:0], rv[1:0], 2'h1 + i[4:3]});
            run(60);
        end
        $display("test stop_random done, mismatches %0d", err_total);
        stop_req <= 1'b0;
        enable_req <= 1'b1;
        cfg_wr(7'h03);
        stop_req <= 1'b1;
        chk_on = 1'b1;
        repeat (5) @(posedge hclk);
        cfg_wr(7'h13);
        chk_on = 1'b1;
        repeat (5) @(posedge hclk);
        stat_chk();
        stop_req <= 1'b0;
        repeat (4) @(posedge hclk);
        stop_req <= 1'b1;
        repeat (5) @(posedge hclk);
        chk_on = 1'b0;
        stat_chk();
        $display("test stop_capture done, mismatches %0d", err_total);
        results();
    end
endmodule : tb_osc_clock_select_gating
